// [mms_pkg.sv]
`default_nettype none
package mms_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_MHZ       = 40;
   localparam int unsigned FAST_STEP_US  = 2;
   localparam int unsigned SLOW_STEP_US  = 100;
   localparam int unsigned PAIR_GAP2_US  = 200;
   localparam int unsigned PAIR_GAP3_US  = 300;
   localparam int unsigned FAST_STEP_CYC = FAST_STEP_US * CLK_MHZ;
   localparam int unsigned SLOW_STEP_CYC = SLOW_STEP_US * CLK_MHZ;
   localparam int unsigned PAIR_GAP2_CYC = PAIR_GAP2_US * CLK_MHZ;
   localparam int unsigned PAIR_GAP3_CYC = PAIR_GAP3_US * CLK_MHZ;
   localparam int unsigned WAIT_W        = 14;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [2:0] ADDR_CFG0 = 3'h0;
   localparam logic [2:0] ADDR_CFG1 = 3'h1;
   localparam logic [2:0] ADDR_CFG2 = 3'h2;
   localparam logic [2:0] ADDR_CFG3 = 3'h3;
   localparam logic [2:0] ADDR_CTRL = 3'h4;
   localparam logic [2:0] ADDR_STAT = 3'h5;

   localparam logic [31:0] CFG0_RST = 32'h0000_0000;
   localparam logic [31:0] CFG1_RST = 32'h0000_0001;
   localparam logic [31:0] CFG2_RST = 32'h0000_0000;
   localparam logic [31:0] CFG3_RST = 32'h0000_0000;
   localparam logic        CTRL_RST = 1'b0;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int unsigned SGAP_LSB    = 16;
   localparam int unsigned SGAP_MSB    = 23;
   localparam int unsigned AVG_LSB     = 0;
   localparam int unsigned AVG_MSB     = 11;
   localparam int unsigned BRIDGE_LSB  = 12;
   localparam int unsigned BRIDGE_MSB  = 13;
   localparam int unsigned SINGLE_BIT  = 2;
   localparam int unsigned CYTIME_LSB  = 4;
   localparam int unsigned CYTIME_MSB  = 13;
   localparam int unsigned STRETCH_LSB = 12;
   localparam int unsigned STRETCH_MSB = 13;
   localparam int unsigned LEAD_LSB    = 17;
   localparam int unsigned LEAD_MSB    = 19;
   localparam int unsigned RUN_BIT     = 0;

   localparam logic [1:0] STRETCH_OFF  = 2'h0;
   localparam logic [1:0] STRETCH_ONE  = 2'h1;
   localparam logic [1:0] STRETCH_PR2  = 2'h2;
   localparam logic [1:0] BRIDGE_HALF  = 2'h0;
   localparam logic [1:0] BRIDGE_FULL  = 2'h1;
   localparam logic [3:0] CPS_HALF     = 4'h2;
   localparam logic [3:0] CPS_FULL     = 4'h4;
   localparam logic [3:0] CPS_QUATTRO  = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_LEAD  = 3'b001,
      ST_DISCH = 3'b010,
      ST_PGAP  = 3'b011,
      ST_INTV  = 3'b100,
      ST_SGAP  = 3'b101
   } mms_state_t;
endpackage : mms_pkg
`default_nettype wire

// [mms_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module mms_tick_gen #(
   parameter int unsigned PERIOD = 80
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // step pulse
   output logic      tick
);
   localparam int unsigned CW = $clog2(PERIOD);
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          tick_reg;
   wire           wrap = (cnt_reg == LAST);

   assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;
   assign tick     = tick_reg;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= wrap;
      end
   end
endmodule : mms_tick_gen
`default_nettype wire

// [mms_sequencer.sv]
// Overview of operation
// (R1) in single conversion the fast oscillator runs only for one sequence, then stays off until the sequence gap expires.
// (R2) stretching keeps the discharge count per sequence and only spreads it in time.
// (R3) stretched continuous measures all the time, oscillator on only around each half bridge.
// (R4) stretched single measures both half-bridge resistors back to back, then waits.
// (R5) spread mode picks oscillator always on while measuring or on for one or two cycles.
// (R6) cycle interval spaces single cycles or pairs, on the fast or the slow time base.
// (R7) averaging count gives the number of ratio measurements per sequence.
// (R8) one-shot clear with spread mode zero means continuous measuring with the oscillator always running.
// (R9) one-shot set means one sequence, then oscillator off while the gap counter runs.
// (R10) spread mode one keeps the oscillator on for one cycle, spacing on the slow base.
// (R11) spread modes two and three hold the oscillator 200 us or 300 us between the pair.
// (R12) spread mode is word 3 bits 13:12 and cycle interval is word 2 bits 13:4.
// (R13) lead time in word 3 bits 19:17 starts the oscillator ahead of the discharge.
// (R14) in stretched single, word 0 bits 23:16 set the time between sequences.
// (R15) the cycle interval counts 2 us steps, or 100 us steps when stretched.
// (R16) one sample is 2, 4 or 8 discharge cycles for half, full or quattro bridge.
// (R17) spread mode zero is unstretched; any other value moves timing to the slow base.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mms_sequencer #(
   parameter int unsigned PAIR_GAP2_CYC = mms_pkg::PAIR_GAP2_CYC,
   parameter int unsigned PAIR_GAP3_CYC = mms_pkg::PAIR_GAP3_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // register port
   input  wire logic [2:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rd_data,
   // front end
   input  wire logic        disch_done,
   output logic             disch_start,
   output logic             osc_en,
   output logic             seq_done
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [31:0] cfg0_reg;
   logic [31:0] cfg1_reg;
   logic [31:0] cfg2_reg;
   logic [31:0] cfg3_reg;
   logic        run_reg;
   logic [31:0] rd_data_reg;
   logic [31:0] rd_data_next;

   mms_pkg::mms_state_t state_reg;
   mms_pkg::mms_state_t state_next;
   logic [mms_pkg::WAIT_W-1:0] wait_reg;
   logic [mms_pkg::WAIT_W-1:0] wait_next;
   logic [15:0] cyc_cnt_reg;
   logic [15:0] cyc_cnt_next;
   logic        half_reg;
   logic        half_next;
   logic        osc_reg;
   logic        osc_next;
   logic        disch_start_reg;
   logic        disch_start_next;
   logic        seq_done_reg;
   logic        seq_done_next;
   logic        tick_fast;
   logic        tick_slow;

   function automatic logic [3:0] cycles_per_sample(input logic [1:0] bridge);
      case (bridge)
         mms_pkg::BRIDGE_HALF: cycles_per_sample = mms_pkg::CPS_HALF;
         mms_pkg::BRIDGE_FULL: cycles_per_sample = mms_pkg::CPS_FULL;
         default:              cycles_per_sample = mms_pkg::CPS_QUATTRO;
      endcase
   endfunction : cycles_per_sample

   // ****************************************************************
   // field decode
   // ****************************************************************
   wire [1:0]  stretch = cfg3_reg[mms_pkg::STRETCH_MSB:mms_pkg::STRETCH_LSB]; // [R12]
   wire [9:0]  cytime  = cfg2_reg[mms_pkg::CYTIME_MSB:mms_pkg::CYTIME_LSB];   // [R12]
   wire        single  = cfg2_reg[mms_pkg::SINGLE_BIT];
   wire [2:0]  lead    = cfg3_reg[mms_pkg::LEAD_MSB:mms_pkg::LEAD_LSB];
   wire [7:0]  sgap    = cfg0_reg[mms_pkg::SGAP_MSB:mms_pkg::SGAP_LSB];
   wire [11:0] avrate  = cfg1_reg[mms_pkg::AVG_MSB:mms_pkg::AVG_LSB];
   wire [1:0]  bridge  = cfg1_reg[mms_pkg::BRIDGE_MSB:mms_pkg::BRIDGE_LSB];

   wire        stretched = (stretch != mms_pkg::STRETCH_OFF);                 // [R17]
   wire        paired    = stretched && (stretch != mms_pkg::STRETCH_ONE);
   wire        cont_mode = run_reg && !single && !stretched;
   // count is independent of the stretch setting
   wire [15:0] total_cyc = {4'h0, avrate} * {12'h000, cycles_per_sample(bridge)}; // [R2] [R7] [R16]
   wire        last_cyc  = (cyc_cnt_reg + 16'h0001) >= total_cyc;
   wire [mms_pkg::WAIT_W-1:0] pgap_load = (stretch == mms_pkg::STRETCH_PR2) ?
      mms_pkg::WAIT_W'(PAIR_GAP2_CYC - 1) : mms_pkg::WAIT_W'(PAIR_GAP3_CYC - 1); // [R11]
   wire [mms_pkg::WAIT_W-1:0] cyt_load  = {4'h0, cytime};
   wire [mms_pkg::WAIT_W-1:0] lead_load = {11'h000, lead};
   wire [mms_pkg::WAIT_W-1:0] sgap_load = {6'h00, sgap};

   // pair gap counts raw clocks, interval fast or slow steps, others slow
   wire wait_step = (state_reg == mms_pkg::ST_PGAP) ? 1'b1 :
                    ((state_reg == mms_pkg::ST_INTV) && !stretched) ? tick_fast : tick_slow; // [R6] [R15]
   wire wait_zero = (wait_reg == '0);

   mms_tick_gen #(.PERIOD(mms_pkg::FAST_STEP_CYC)) u_tick_fast (
      .ref_clk (ref_clk),
      .srst    (srst),
      .tick    (tick_fast)
   );
   mms_tick_gen #(.PERIOD(mms_pkg::SLOW_STEP_CYC)) u_tick_slow (
      .ref_clk (ref_clk),
      .srst    (srst),
      .tick    (tick_slow)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb begin
      state_next       = state_reg;
      wait_next        = wait_reg;
      cyc_cnt_next     = cyc_cnt_reg;
      half_next        = half_reg;
      disch_start_next = 1'b0;
      seq_done_next    = 1'b0;
      if (!wait_zero && wait_step) begin
         wait_next = wait_reg - 1'b1;
      end
      case (state_reg)
         mms_pkg::ST_IDLE: begin
            cyc_cnt_next = '0;
            half_next    = 1'b0;
            if (run_reg) begin
               state_next = mms_pkg::ST_LEAD;
               wait_next  = lead_load; // [R13]
            end
         end
         mms_pkg::ST_LEAD: begin
            if (wait_zero) begin
               state_next       = mms_pkg::ST_DISCH;
               disch_start_next = 1'b1;
            end
         end
         mms_pkg::ST_DISCH: begin
            if (disch_done) begin
               if (last_cyc) begin
                  cyc_cnt_next  = '0;
                  half_next     = 1'b0;
                  seq_done_next = 1'b1;
                  // one-shot rests until the gap counter expires
                  state_next    = single ? mms_pkg::ST_SGAP : mms_pkg::ST_INTV; // [R9] [R14]
                  wait_next     = single ? sgap_load : cyt_load;
               end else if (paired && !half_reg) begin
                  cyc_cnt_next = cyc_cnt_reg + 16'h0001;
                  half_next    = 1'b1;
                  state_next   = mms_pkg::ST_PGAP; // [R4] [R11]
                  wait_next    = pgap_load;
               end else begin
                  cyc_cnt_next = cyc_cnt_reg + 16'h0001;
                  half_next    = 1'b0;
                  state_next   = mms_pkg::ST_INTV; // [R6]
                  wait_next    = cyt_load;
               end
            end
         end
         mms_pkg::ST_PGAP: begin
            if (wait_zero) begin
               state_next       = mms_pkg::ST_DISCH;
               disch_start_next = 1'b1;
            end
         end
         mms_pkg::ST_INTV, mms_pkg::ST_SGAP: begin
            if (!run_reg) begin
               state_next = mms_pkg::ST_IDLE;
            end else if (wait_zero) begin
               if (stretched || state_reg == mms_pkg::ST_SGAP) begin
                  // oscillator was off, so it needs its lead time again
                  state_next = mms_pkg::ST_LEAD; // [R3] [R13]
                  wait_next  = lead_load;
               end else begin
                  state_next       = mms_pkg::ST_DISCH;
                  disch_start_next = 1'b1;
               end
            end
         end
         default: begin
            state_next = mms_pkg::ST_IDLE;
         end
      endcase
   end

   // oscillator follows the next state so it lines up with state_reg
   always_comb begin
      case (state_next)
         mms_pkg::ST_LEAD, mms_pkg::ST_DISCH, mms_pkg::ST_PGAP: osc_next = 1'b1; // [R5] [R10]
         mms_pkg::ST_INTV: osc_next = !stretched; // [R3] [R10]
         mms_pkg::ST_SGAP: osc_next = 1'b0;       // [R1] [R9]
         default:          osc_next = 1'b0;
      endcase
      if (cont_mode && state_next != mms_pkg::ST_IDLE) begin
         osc_next = 1'b1; // [R8]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg       <= mms_pkg::ST_IDLE;
         wait_reg        <= '0;
         cyc_cnt_reg     <= '0;
         half_reg        <= 1'b0;
         osc_reg         <= 1'b0;
         disch_start_reg <= 1'b0;
         seq_done_reg    <= 1'b0;
      end else begin
         state_reg       <= state_next;
         wait_reg        <= wait_next;
         cyc_cnt_reg     <= cyc_cnt_next;
         half_reg        <= half_next;
         osc_reg         <= osc_next;
         disch_start_reg <= disch_start_next;
         seq_done_reg    <= seq_done_next;
      end
   end

   // ****************************************************************
   // register port
   // ****************************************************************
   always_comb begin
      case (addr)
         mms_pkg::ADDR_CFG0: rd_data_next = cfg0_reg;
         mms_pkg::ADDR_CFG1: rd_data_next = cfg1_reg;
         mms_pkg::ADDR_CFG2: rd_data_next = cfg2_reg;
         mms_pkg::ADDR_CFG3: rd_data_next = cfg3_reg;
         mms_pkg::ADDR_CTRL: rd_data_next = {31'h0000_0000, run_reg};
         mms_pkg::ADDR_STAT: rd_data_next = {cyc_cnt_reg, 11'h000, half_reg, osc_reg,
                                             state_reg};
         default:            rd_data_next = 32'h0000_0000;
      endcase
      if (!rd_en) begin
         rd_data_next = 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg0_reg    <= mms_pkg::CFG0_RST;
         cfg1_reg    <= mms_pkg::CFG1_RST;
         cfg2_reg    <= mms_pkg::CFG2_RST;
         cfg3_reg    <= mms_pkg::CFG3_RST;
         run_reg     <= mms_pkg::CTRL_RST;
         rd_data_reg <= 32'h0000_0000;
      end else begin
         rd_data_reg <= rd_data_next;
         if (wr_en && addr == mms_pkg::ADDR_CFG0) cfg0_reg <= wr_data;
         if (wr_en && addr == mms_pkg::ADDR_CFG1) cfg1_reg <= wr_data;
         if (wr_en && addr == mms_pkg::ADDR_CFG2) cfg2_reg <= wr_data;
         if (wr_en && addr == mms_pkg::ADDR_CFG3) cfg3_reg <= wr_data;
         if (wr_en && addr == mms_pkg::ADDR_CTRL) run_reg <= wr_data[mms_pkg::RUN_BIT];
      end
   end

   assign rd_data     = rd_data_reg;
   assign osc_en      = osc_reg;
   assign disch_start = disch_start_reg;
   assign seq_done    = seq_done_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [mms_pkg::WAIT_W-1:0] pgap_cnt_reg;
   always_ff @(posedge ref_clk) begin
      if (srst || state_reg != mms_pkg::ST_PGAP) begin
         pgap_cnt_reg <= '0;
      end else begin
         pgap_cnt_reg <= pgap_cnt_reg + 1'b1;
      end
   end

   // discharges started in this sequence, counted apart from cyc_cnt_reg
   logic [15:0] seq_disch_reg;
   always_ff @(posedge ref_clk) begin
      if (srst || seq_done || state_reg == mms_pkg::ST_IDLE) begin
         seq_disch_reg <= '0;
      end else if (disch_start) begin
         seq_disch_reg <= seq_disch_reg + 16'h0001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_osc_off_gap: assert property ( // [R1]
      state_reg == mms_pkg::ST_SGAP |-> !osc_en)
      else $error("oscillator on during sequence gap");
   a_cont_osc_on: assert property ( // [R8]
      state_reg != mms_pkg::ST_IDLE && $past(cont_mode) |-> osc_en)
      else $error("oscillator off in continuous mode");
   a_intv_osc_off: assert property ( // [R3]
      state_reg == mms_pkg::ST_INTV && $past(stretched) |-> !osc_en)
      else $error("oscillator on in stretched interval");
   a_disch_osc_on: assert property ( // [R5]
      state_reg == mms_pkg::ST_DISCH |-> osc_en)
      else $error("discharge without oscillator");
   a_disch_entry: assert property ( // [R2]
      disch_start |-> state_reg == mms_pkg::ST_DISCH && $past(state_reg) != mms_pkg::ST_DISCH)
      else $error("discharge start not at entry");
   a_seq_len: assert property ( // [R7]
      seq_done |-> seq_disch_reg == ((total_cyc == '0) ? 16'h0001 : total_cyc))
      else $error("sequence ended with wrong cycle count");
   a_pair_gap_len: assert property ( // [R11]
      state_reg == mms_pkg::ST_PGAP ##1 state_reg == mms_pkg::ST_DISCH
      |-> 32'($past(pgap_cnt_reg)) + 32'h0000_0001 ==
          (($past(stretch) == mms_pkg::STRETCH_PR2) ? PAIR_GAP2_CYC : PAIR_GAP3_CYC))
      else $error("pair gap length wrong");
   a_pair_follow: assert property ( // [R4]
      state_reg == mms_pkg::ST_PGAP ##1 state_reg != mms_pkg::ST_PGAP
      |-> state_reg == mms_pkg::ST_DISCH && disch_start)
      else $error("pair gap not followed by discharge");
   a_single_gap: assert property ( // [R14]
      seq_done && $past(single) |-> state_reg == mms_pkg::ST_SGAP)
      else $error("single mode did not enter gap");

   c_seq_cont:   cover property (seq_done && cont_mode);
   c_seq_single: cover property (state_reg == mms_pkg::ST_SGAP ##1 state_reg == mms_pkg::ST_LEAD);
   c_pair:       cover property (state_reg == mms_pkg::ST_PGAP ##1 state_reg == mms_pkg::ST_DISCH);
endmodule : mms_sequencer
`default_nettype wire

// [mms_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module mms_sequencer_bench;
   // shortened pair gaps keep the run brief; expectations follow them
   localparam int unsigned GAP2 = 20;
   localparam int unsigned GAP3 = 30;
   localparam int unsigned SLOW = mms_pkg::SLOW_STEP_CYC;
   localparam int unsigned FAST = mms_pkg::FAST_STEP_CYC;

   logic        ref_clk;
   logic        srst;
   logic [2:0]  addr;
   logic [31:0] wr_data;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] rd_data;
   logic        disch_done;
   logic        disch_start;
   logic        osc_en;
   logic        seq_done;
   int          error_cnt;
   int          samples_checked;

   mms_sequencer #(.PAIR_GAP2_CYC(GAP2), .PAIR_GAP3_CYC(GAP3)) DUT (
      .ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .disch_done(disch_done),
      .disch_start(disch_start), .osc_en(osc_en), .seq_done(seq_done));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ****************************************************************
   // checking and bus tasks
   // ****************************************************************
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic in_range(input int v, input int lo, input int hi);
      check({31'h0, (v >= lo) && (v <= hi)}, 32'h0000_0001);
   endtask : in_range

   task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask : reg_rd

   // ****************************************************************
   // one measurement sequence in a given mode
   // ****************************************************************
   task automatic run_seq(input logic os, input logic [1:0] spr, input logic [9:0] cy,
                          input logic [2:0] lead, input logic [1:0] brg,
                          input logic [11:0] avr, input int exp_n);
      int          n, since, pre, osc_bad, dly, t, step, pgap, k, pend;
      logic [31:0] st;
      step = (spr == mms_pkg::STRETCH_OFF) ? FAST : SLOW;
      pgap = (spr == 2'h3) ? GAP3 : GAP2;
      n = 0;
      since = 0;
      pre = 0;
      osc_bad = 0;
      pend = 0;
      dly = 0;
      reg_wr(mms_pkg::ADDR_CFG0, 32'h0002_0000);
      reg_wr(mms_pkg::ADDR_CFG1, {18'h0, brg, avr});
      reg_wr(mms_pkg::ADDR_CFG2, {18'h0, cy, 1'b0, os, 2'b00});
      reg_wr(mms_pkg::ADDR_CFG3, {12'h0, lead, 3'h0, spr, 12'h0});
      reg_wr(mms_pkg::ADDR_CTRL, 32'h0000_0001);
      for (t = 0; t < 40000 && seq_done !== 1'b1; t++) begin
         @(posedge ref_clk);
         disch_done <= (dly == 1);
         if (dly != 0) dly--;
         #1;
         if (n == 0 && osc_en === 1'b1 && disch_start !== 1'b1) pre++;
         if (disch_start === 1'b1) begin
            check({31'h0, osc_en}, 32'h0000_0001);
            if (n == 0) begin
               if (lead == 3'h0) in_range(pre, 1, 2);
               else in_range(pre, (lead - 1) * SLOW + 1, lead * SLOW + 2);
            end else if (spr >= mms_pkg::STRETCH_PR2 && n % 2 == 1) begin
               in_range(since, pgap, pgap + 5);
            end else begin
               in_range(since, (int'(cy) - 1) * step, int'(cy) * step + 5);
            end
            n++;
            dly = 3;
            since = 0;
            pend = 0;
         end else if (disch_done === 1'b1) begin
            since = 0;
         end else begin
            since++;
            // the lead cycle before a discharge shows the oscillator, so count a cycle late
            osc_bad += pend;
            // oscillator held through a pair gap, and in gaps only when unstretched
            pend = (n > 0 && since >= 3 && dly == 0 && osc_en !==
                    ((spr >= mms_pkg::STRETCH_PR2 && n % 2 == 1) || spr == mms_pkg::STRETCH_OFF));
         end
      end
      if (seq_done !== 1'b1) begin
         error_cnt++;
         test_done();
      end
      check(32'(n), 32'(exp_n));
      check(32'(osc_bad), 32'h0000_0000);
      @(posedge ref_clk);
      #1;
      check({31'h0, osc_en}, {31'h0, !os && spr == mms_pkg::STRETCH_OFF});
      if (os) begin
         for (k = 0; k < 20000 && osc_en !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
         end
         in_range(k + 1, SLOW, 2 * SLOW + 3);
         if (osc_en !== 1'b1) test_done();
      end
      // done held high so any discharge in flight finishes and run can drop
      @(posedge ref_clk);
      disch_done <= 1'b1;
      reg_wr(mms_pkg::ADDR_CTRL, 32'h0000_0000);
      st = 32'hFFFF_FFFF;
      for (k = 0; k < 5000 && st[2:0] !== 3'h0; k++) reg_rd(mms_pkg::ADDR_STAT, st);
      check({29'h0, st[2:0]}, 32'h0000_0000);
      if (st[2:0] !== 3'h0) test_done();
      check({31'h0, osc_en}, 32'h0000_0000);
      @(posedge ref_clk);
      disch_done <= 1'b0;
   endtask : run_seq

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin : main
      logic [31:0] d;
      logic [31:0] wv [3];
      logic [2:0]  wa [3];
      int          a;
      error_cnt = 0;
      samples_checked = 0;
      srst = 1'b1;
      addr = 3'h0;
      wr_data = 32'h0000_0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      disch_done = 1'b0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      check({29'h0, disch_start, osc_en, seq_done}, 32'h0000_0000);
      for (a = 0; a < 8; a++) begin
         reg_rd(3'(a), d);
         check(d, (a == 1) ? mms_pkg::CFG1_RST : 32'h0000_0000);
      end
      @(posedge ref_clk);
      #1;
      check(rd_data, 32'h0000_0000);
      reg_wr(3'h6, 32'hFFFF_FFFF);
      reg_rd(3'h6, d);
      check(d, 32'h0000_0000);
      wa = '{mms_pkg::ADDR_CFG0, mms_pkg::ADDR_CFG2, mms_pkg::ADDR_CFG3};
      wv = '{32'h00FF_0000, 32'h0000_3FF4, 32'h000E_3000};
      for (a = 0; a < 3; a++) begin
         reg_wr(wa[a], wv[a]);
         reg_rd(wa[a], d);
         check(d, wv[a]);
      end
      run_seq(1'b0, 2'h0, 10'h005, 3'h0, mms_pkg::BRIDGE_HALF, 12'h001, 2);
      run_seq(1'b1, 2'h0, 10'h003, 3'h0, mms_pkg::BRIDGE_FULL, 12'h002, 8);
      run_seq(1'b1, 2'h0, 10'h001, 3'h2, 2'h2, 12'h001, 8);
      run_seq(1'b1, 2'h1, 10'h001, 3'h0, mms_pkg::BRIDGE_HALF, 12'h002, 4);
      run_seq(1'b0, 2'h2, 10'h001, 3'h0, mms_pkg::BRIDGE_HALF, 12'h001, 2);
      run_seq(1'b1, 2'h3, 10'h002, 3'h0, mms_pkg::BRIDGE_FULL, 12'h001, 4);
      test_done();
   end
endmodule : mms_sequencer_bench
`default_nettype wire
